// >>> common/lhss_map.svh
// Register map, field positions, reset values and timing counts of the
// LIN hardware synchronisation status logic.
// Assumes a 100 MHz system clock and an APB bus with 32-bit data.
//
// Summary of operation
// - Slave-only LIN 2.0 node, bus rates 1 kBaud to 20 kBaud.
// - Break timer runs from low-power oscillator; sync timing from 5 MHz.
// - Six synchronisation registers: status, control, edges, sync, break, sync compare.
// - Status is 32-bit, read-only, resets to zero; bits 31..7 read zero.
// - Bit-serial bus mode only: rising bus edge sets status bit 6.
// - Finished software reset of synchronisation hardware sets status bit 5.
// - Break timer overflow sets status bit 4 and raises interrupt request.
// - Sync bit timer equal to compare register sets status bit 3.
// - Configured stop condition of sync measurement sets status bit 2.
// - Configured start condition of sync measurement sets status bit 1.
// - Break timer reaching break compare value sets status bit 0.
// - Reading the status register clears the flags that the read returned.
// - Control bit 12 masks rise interrupt in serial mode, enables in LIN.
`ifndef LHSS_MAP_SVH
`define LHSS_MAP_SVH

// ==========================================================================
// Byte addresses
// ==========================================================================
`define LHSS_ADDR_STATUS 32'hffff0780
`define LHSS_ADDR_CTRL0 32'hffff0784
`define LHSS_ADDR_EDGE 32'hffff0788
`define LHSS_ADDR_SYNC_VAL 32'hffff078c
`define LHSS_ADDR_BREAK_VAL 32'hffff0790
`define LHSS_ADDR_SYNC_CMP 32'hffff0794

// ==========================================================================
// Status bit positions
// ==========================================================================
`define LHSS_ST_BREAK 0
`define LHSS_ST_START 1
`define LHSS_ST_STOP 2
`define LHSS_ST_CMP 3
`define LHSS_ST_BRK_ERR 4
`define LHSS_ST_RST_DONE 5
`define LHSS_ST_RISE 6
`define LHSS_ST_W 7

// ==========================================================================
// Control and edge select fields
// ==========================================================================
`define LHSS_C0_EN 0
`define LHSS_C0_SWRST 1
`define LHSS_C0_BSD 2
`define LHSS_C0_RISE_IE 12
`define LHSS_C0_W 13
`define LHSS_E_START_RISE 0
`define LHSS_E_STOP_RISE 1
`define LHSS_E_CNT_LSB 4
`define LHSS_E_CNT_MSB 7
`define LHSS_E_W 8

// ==========================================================================
// Reset values
// ==========================================================================
`define LHSS_RST_STATUS 7'h00
`define LHSS_RST_CTRL0 13'h0000
`define LHSS_RST_EDGE 8'h40
`define LHSS_RST_SYNC_CMP 16'hffff
`define LHSS_RST_BREAK_CMP 12'h0ff

// ==========================================================================
// Timing
// ==========================================================================
`define LHSS_CLK_MHZ 100
`define LHSS_SYNC_MHZ 5
`define LHSS_SYNC_DIV (`LHSS_CLK_MHZ / `LHSS_SYNC_MHZ)
`define LHSS_BAUD_MIN 1000
`define LHSS_BAUD_MAX 20000

`endif

// >>> common/lhss_pkg.sv
// Types shared by the LIN hardware synchronisation status logic.
// Assumes nothing of its surroundings.
package lhss_pkg;

   // Phases of one synchronisation byte measurement.
   typedef enum logic [1:0] {
      SYNC_IDLE,
      SYNC_WAIT_START,
      SYNC_COUNT
   } lhss_sync_state_t;

   typedef logic [6:0] lhss_flags_t;

endpackage

// >>> logic/lhss_event_flag.sv
// One sticky event flag with a clear that yields to a simultaneous set.
// Assumes set and clear are synchronous to clk.
`timescale 1ns/1ps
module lhss_event_flag (
   input wire logic clk,
   input wire logic rst,
   input wire logic set,
   input wire logic clr,
   output logic q
);

   // A clear never wins over an event in the same cycle.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= 1'b0;
      end else begin
         q <= set | (q & ~clr);
      end
   end

   set_wins_a: assert property (@(posedge clk) disable iff (rst)
      set |=> q)
      else $error("Flag lost an event that coincided with a clear.");

endmodule

// >>> logic/lhss_top.sv
// LIN hardware synchronisation status logic with its APB register file.
// Assumes a 100 MHz clock, LIN_RX and LP_OSC_TICK synchronous to it, and
// an APB master that follows the usual setup and access phases.
`timescale 1ns/1ps
`include "lhss_map.svh"
module lhss_top
   import lhss_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic LIN_RX,
   input wire logic LP_OSC_TICK,
   output logic IRQ_REQ
);

   // =======================================================================
   // Register state
   // =======================================================================
   logic [`LHSS_C0_W-1:0] ctrl0_q;
   logic [`LHSS_E_W-1:0] edge_q;
   logic [15:0] sync_cmp_q;
   logic [11:0] break_cmp_q;
   logic swrst_q;
   lhss_flags_t flag_q;
   lhss_flags_t flag_set;
   lhss_flags_t flag_clr;

   // =======================================================================
   // APB decode
   // =======================================================================
   // One wait state: the first access cycle captures read data, the
   // second completes the transfer with PREADY high.
   wire apb_capture = PSEL & PENABLE & ~PREADY;
   wire apb_done = PSEL & PENABLE & PREADY;
   wire hit_status = (PADDR == `LHSS_ADDR_STATUS);
   wire hit_ctrl0 = (PADDR == `LHSS_ADDR_CTRL0);
   wire hit_edge = (PADDR == `LHSS_ADDR_EDGE);
   wire hit_sync_val = (PADDR == `LHSS_ADDR_SYNC_VAL);
   wire hit_break_val = (PADDR == `LHSS_ADDR_BREAK_VAL);
   wire hit_sync_cmp = (PADDR == `LHSS_ADDR_SYNC_CMP);
   wire hit_any = hit_status | hit_ctrl0 | hit_edge | hit_sync_val |
                  hit_break_val | hit_sync_cmp;
   // The status register is read-only, so a write to it is an error.
   wire bad_access = ~hit_any | (hit_status & PWRITE);
   wire wr_ok = apb_done & PWRITE & hit_any & ~hit_status;
   wire wr_ctrl0 = wr_ok & hit_ctrl0;
   wire wr_edge = wr_ok & hit_edge;
   wire wr_break_cmp = wr_ok & hit_break_val;
   wire wr_sync_cmp = wr_ok & hit_sync_cmp;
   wire status_rd_done = apb_done & ~PWRITE & hit_status;

   // =======================================================================
   // Mode decode
   // =======================================================================
   wire sync_en = ctrl0_q[`LHSS_C0_EN];
   wire bsd_mode = ctrl0_q[`LHSS_C0_BSD];
   // Bit 12 masks in bit-serial mode but enables in LIN mode.
   wire rise_irq_on = bsd_mode ? ~ctrl0_q[`LHSS_C0_RISE_IE]
                               : ctrl0_q[`LHSS_C0_RISE_IE];
   wire start_rise = edge_q[`LHSS_E_START_RISE];
   wire stop_rise = edge_q[`LHSS_E_STOP_RISE];
   wire [3:0] stop_count = edge_q[`LHSS_E_CNT_MSB:`LHSS_E_CNT_LSB];

   // =======================================================================
   // Bus edges
   // =======================================================================
   // The device only listens on the bus; it never answers a header on
   // its own, so there is no transmit path here.
   logic rx_q;
   wire rx_rise = LIN_RX & ~rx_q;
   wire rx_fall = ~LIN_RX & rx_q;
   wire start_edge = start_rise ? rx_rise : rx_fall;
   wire stop_edge = stop_rise ? rx_rise : rx_fall;

   // Idle level of the bus is high, so the history starts high.
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         rx_q <= 1'b1;
      end else begin
         rx_q <= LIN_RX;
      end
   end

   // =======================================================================
   // 5 MHz sync tick
   // =======================================================================
   // Deriving the tick from the system clock keeps one clock domain; the
   // timer resolution is 200 ns, plenty at 20 kBaud.
   localparam logic [4:0] SYNC_DIV_LAST = 5'(`LHSS_SYNC_DIV - 1);
   logic [4:0] div_q;
   wire sync_tick = (div_q == SYNC_DIV_LAST);

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         div_q <= 5'h00;
      end else begin
         div_q <= sync_tick ? 5'h00 : div_q + 5'h01;
      end
   end

   // =======================================================================
   // Software reset of the synchronisation hardware
   // =======================================================================
   // A write with the reset bit arms a request; the following cycle
   // clears timers and state and reports completion.
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         swrst_q <= 1'b0;
      end else begin
         swrst_q <= wr_ctrl0 & PWDATA[`LHSS_C0_SWRST];
      end
   end

   // =======================================================================
   // Break timer
   // =======================================================================
   // Counts low-power oscillator ticks while the bus is low. After an
   // overflow it holds until the bus returns high, so one long low level
   // gives one error and not a stream of them.
   logic [11:0] brk_q;
   logic brk_ovf_q;
   wire brk_count = ~LIN_RX & LP_OSC_TICK & ~brk_ovf_q & ~swrst_q;
   wire [11:0] brk_next = brk_q + 12'h001;
   wire brk_ovf_ev = brk_count & (brk_q == 12'hfff);
   wire brk_valid_ev = brk_count & ~brk_ovf_ev &
                       (brk_next == break_cmp_q);

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         brk_q <= 12'h000;
         brk_ovf_q <= 1'b0;
      end else if (swrst_q | LIN_RX) begin
         brk_q <= 12'h000;
         brk_ovf_q <= 1'b0;
      end else if (brk_count) begin
         brk_q <= brk_ovf_ev ? brk_q : brk_next;
         brk_ovf_q <= brk_ovf_ev;
      end
   end

   // =======================================================================
   // Synchronisation byte measurement
   // =======================================================================
   // The 16-bit timer spans a whole sync byte even at 1 kBaud, which is
   // 40000 ticks of 200 ns for eight bit times.
   lhss_sync_state_t state_q;
   lhss_sync_state_t state_d;
   logic [15:0] sync_q;
   logic [3:0] edges_q;
   wire counting = (state_q == SYNC_COUNT);
   wire start_ev = (state_q == SYNC_WAIT_START) & sync_en & start_edge &
                   ~swrst_q;
   wire [3:0] edges_next = edges_q + 4'h1;
   wire stop_ev = counting & stop_edge & (edges_next == stop_count) &
                  ~swrst_q;
   wire [15:0] sync_next = sync_q + 16'h0001;
   wire cmp_ev = counting & sync_tick & ~swrst_q &
                 (sync_next == sync_cmp_q);

   // Next-state choice for the measurement sequence.
   always_comb begin
      state_d = state_q;
      case (state_q)
         SYNC_IDLE: begin
            if (sync_en) begin
               state_d = SYNC_WAIT_START;
            end
         end
         SYNC_WAIT_START: begin
            if (!sync_en) begin
               state_d = SYNC_IDLE;
            end else if (start_edge) begin
               state_d = SYNC_COUNT;
            end
         end
         SYNC_COUNT: begin
            if (!sync_en || stop_ev) begin
               state_d = SYNC_IDLE;
            end
         end
         default: begin
            state_d = SYNC_IDLE;
         end
      endcase
   end

   // State, timer and edge count; the timer holds its value after the
   // stop so software can read the measured byte length.
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         state_q <= SYNC_IDLE;
         sync_q <= 16'h0000;
         edges_q <= 4'h0;
      end else if (swrst_q) begin
         state_q <= SYNC_IDLE;
         sync_q <= 16'h0000;
         edges_q <= 4'h0;
      end else begin
         state_q <= state_d;
         if (start_ev) begin
            sync_q <= 16'h0000;
            edges_q <= 4'h0;
         end else if (counting) begin
            sync_q <= sync_tick ? sync_next : sync_q;
            edges_q <= stop_edge ? edges_next : edges_q;
         end
      end
   end

   // =======================================================================
   // Control registers
   // =======================================================================
   // The reset bit is a command and is never stored.
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         ctrl0_q <= `LHSS_RST_CTRL0;
         edge_q <= `LHSS_RST_EDGE;
         sync_cmp_q <= `LHSS_RST_SYNC_CMP;
         break_cmp_q <= `LHSS_RST_BREAK_CMP;
      end else begin
         if (wr_ctrl0) begin
            ctrl0_q <= PWDATA[`LHSS_C0_W-1:0] &
                       ~(13'h0001 << `LHSS_C0_SWRST);
         end
         if (wr_edge) begin
            edge_q <= PWDATA[`LHSS_E_W-1:0];
         end
         if (wr_sync_cmp) begin
            sync_cmp_q <= PWDATA[15:0];
         end
         if (wr_break_cmp) begin
            break_cmp_q <= PWDATA[11:0];
         end
      end
   end

   // =======================================================================
   // Status flags
   // =======================================================================
   // Only the bits that software actually saw are cleared, so an event
   // landing between capture and completion still shows on the next read.
   assign flag_set[`LHSS_ST_BREAK] = brk_valid_ev;
   assign flag_set[`LHSS_ST_START] = start_ev;
   assign flag_set[`LHSS_ST_STOP] = stop_ev;
   assign flag_set[`LHSS_ST_CMP] = cmp_ev;
   assign flag_set[`LHSS_ST_BRK_ERR] = brk_ovf_ev;
   assign flag_set[`LHSS_ST_RST_DONE] = swrst_q;
   assign flag_set[`LHSS_ST_RISE] = bsd_mode & rx_rise;
   assign flag_clr = status_rd_done ? PRDATA[`LHSS_ST_W-1:0]
                                    : `LHSS_RST_STATUS;

   genvar gi;
   generate
      for (gi = 0; gi < `LHSS_ST_W; gi++) begin : g_flag
         lhss_event_flag u_flag (
            .clk(CLOCK),
            .rst(RESET),
            .set(flag_set[gi]),
            .clr(flag_clr[gi]),
            .q(flag_q[gi])
         );
      end
   endgenerate

   // =======================================================================
   // Read data mux
   // =======================================================================
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_status) begin
         rd_mux = {25'h0000000, flag_q};
      end else if (hit_ctrl0) begin
         rd_mux = {19'h00000, ctrl0_q};
      end else if (hit_edge) begin
         rd_mux = {24'h000000, edge_q};
      end else if (hit_sync_val) begin
         rd_mux = {16'h0000, sync_q};
      end else if (hit_break_val) begin
         rd_mux = {20'h00000, brk_q};
      end else if (hit_sync_cmp) begin
         rd_mux = {16'h0000, sync_cmp_q};
      end
   end

   // =======================================================================
   // APB answer and interrupt request
   // =======================================================================
   // The interrupt follows the flags by one cycle so it comes from a
   // flip-flop like every other output.
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h0000_0000;
         IRQ_REQ <= 1'b0;
      end else begin
         PREADY <= apb_capture;
         PSLVERR <= apb_capture & bad_access;
         if (apb_capture) begin
            PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
         end
         IRQ_REQ <= flag_q[`LHSS_ST_BRK_ERR] |
                    (flag_q[`LHSS_ST_RISE] & rise_irq_on);
      end
   end

   // =======================================================================
   // Checks
   // =======================================================================
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);

   status_upper_zero_a: assert property (
      (PREADY && PSEL && !PWRITE && hit_status) |-> PRDATA[31:7] == 25'h0)
      else $error("Reserved status bits read nonzero.");

   rise_mode_only_a: assert property (
      $rose(flag_q[6]) |-> $past(bsd_mode) && $past(rx_rise))
      else $error("Rise flag set outside bit-serial mode.");

   reset_done_a: assert property (
      (wr_ctrl0 && PWDATA[1]) |=> ##1 flag_q[5] && sync_q == 16'h0)
      else $error("Software reset did not report completion.");

   break_error_a: assert property (
      brk_ovf_ev |=> flag_q[4] ##1 IRQ_REQ)
      else $error("Break overflow did not flag and interrupt.");

   compare_hit_a: assert property (
      cmp_ev |=> flag_q[3] && sync_q == sync_cmp_q)
      else $error("Compare match not flagged with equal timer.");

   stop_flag_a: assert property (
      stop_ev |=> flag_q[2] && state_q == SYNC_IDLE)
      else $error("Stop condition not flagged or not ending count.");

   start_flag_a: assert property (
      start_ev |=> flag_q[1] && counting && sync_q == 16'h0)
      else $error("Start condition not flagged or count not begun.");

   break_valid_a: assert property (
      brk_valid_ev |=> flag_q[0] && brk_q == break_cmp_q)
      else $error("Valid break not flagged at compare value.");

   read_clear_a: assert property (
      status_rd_done |=>
         (flag_q & $past(PRDATA[6:0] & ~flag_set)) == 7'h00)
      else $error("Status read left a reported flag set.");

   rise_mask_a: assert property (
      (flag_q == 7'h40 && bsd_mode && ctrl0_q[12]) |=> !IRQ_REQ)
      else $error("Masked rise interrupt still raised.");

   sync_tick_rate_a: assert property (
      sync_tick |-> ##20 sync_tick)
      else $error("Sync tick not at 5 MHz.");

endmodule

// >>> test/lhss_lin_master.sv
// Behavioural LIN master node driving the receive line of the block.
// Assumes the caller enters its task just after a rising clock edge.
`timescale 1ns/1ps
module lhss_lin_master (
   input wire logic clk,
   output logic lin_rx
);
   // ==========================================================
   // Bus level
   // ==========================================================
   // The slave pull-up keeps an undriven bus recessive, so idle is high.
   initial begin
      lin_rx = 1'b1;
   end

   // Drive one level for a number of clocks; a short count gives a prompt
   // edge and a long one a slow master, so the bench can mimic both.
   task automatic hold(input logic lvl, input int cycles);
      @(posedge clk);
      lin_rx <= lvl;
      repeat (cycles - 1) @(posedge clk);
   endtask
endmodule

// >>> test/testbench.sv
// Self-checking bench for the LIN synchronisation status logic.
// Assumes an APB slave that raises PREADY in its own time.
`timescale 1ns/1ps
`include "lhss_map.svh"
module testbench;
   logic CLOCK, RESET, PSEL, PENABLE, PWRITE, LP_OSC_TICK;
   logic [31:0] PADDR, PWDATA, PRDATA;
   logic PREADY, PSLVERR, LIN_RX, IRQ_REQ;
   logic [31:0] r1, r2;
   logic e1;
   int n_mismatch = 0;
   int total_checks = 0;
   typedef struct {logic w; logic [31:0] a, d, x; logic e;} lhss_row_t;
   lhss_row_t rows [12] = '{
      '{0, `LHSS_ADDR_STATUS, 0, 0, 0},
      '{0, `LHSS_ADDR_CTRL0, 0, 0, 0},
      '{0, `LHSS_ADDR_EDGE, 0, 32'h40, 0},
      '{0, `LHSS_ADDR_SYNC_CMP, 0, 32'hffff, 0},
      '{0, `LHSS_ADDR_SYNC_VAL, 0, 0, 0},
      '{0, `LHSS_ADDR_BREAK_VAL, 0, 0, 0},
      '{1, `LHSS_ADDR_STATUS, 32'hffffffff, 0, 1},
      '{0, `LHSS_ADDR_STATUS, 0, 0, 0},
      '{1, 32'hffff0798, 32'h1, 0, 1},
      '{0, 32'hffff0798, 0, 0, 1},
      '{1, `LHSS_ADDR_SYNC_CMP, 32'h12345678, 0, 0},
      '{0, `LHSS_ADDR_SYNC_CMP, 0, 32'h5678, 0}};

   lhss_top i_dut (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .LIN_RX(LIN_RX), .LP_OSC_TICK(LP_OSC_TICK), .IRQ_REQ(IRQ_REQ));
   lhss_lin_master i_master (.clk(CLOCK), .lin_rx(LIN_RX));

   // ==========================================================
   // Clock, verdict and comparison
   // ==========================================================
   // Free-running 100 MHz clock.
   initial begin
      CLOCK = 1'b0;
      forever #5 CLOCK = ~CLOCK;
   end

   task automatic test_done;
      if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] x, g);
      total_checks++;
      if (g !== x) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
      end
   endtask

   // ==========================================================
   // APB master
   // ==========================================================
   // One transfer; tk picks the cycle in which an oscillator tick lands
   // (0 setup, 1 and 2 access, other none) so events can collide with it.
   task automatic apb(input logic w, input logic [31:0] a, d, input int tk,
      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      LP_OSC_TICK <= (tk == 0);
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      LP_OSC_TICK <= (tk == 1);
      // Only the watchdog ends a wait; the slave sets its own pace.
      do begin
         @(posedge CLOCK);
         n++;
         if (PREADY !== 1'b1) begin
            LP_OSC_TICK <= (tk == n + 1);
         end
      end while (PREADY !== 1'b1);
      r = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      LP_OSC_TICK <= 1'b0;
      // One idle edge, so the next call never drives a signal twice.
      @(posedge CLOCK);
   endtask

   task automatic wr(input logic [31:0] a, d);
      apb(1'b1, a, d, 9, r1, e1);
   endtask

   task automatic rdc(input logic [31:0] a, x);
      apb(1'b0, a, 0, 9, r1, e1);
      chk($sformatf("read %h", a), x, r1);
   endtask

   // Oscillator ticks are one-cycle pulses with a gap between them.
   task automatic tick(input int n);
      repeat (n) begin
         LP_OSC_TICK <= 1'b1;
         @(posedge CLOCK);
         LP_OSC_TICK <= 1'b0;
         @(posedge CLOCK);
      end
   endtask

   // A slow timeout: the whole run needs roughly 8700 clocks.
   initial begin
      #600000;
      n_mismatch++;
      test_done();
   end

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      {RESET, PSEL, PENABLE, PWRITE, LP_OSC_TICK} = 5'h10;
      PADDR = 0;
      PWDATA = 0;
      repeat (8) @(posedge CLOCK);
      RESET <= 1'b0;
      @(posedge CLOCK);
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d, 9, r1, e1);
         chk("row data", rows[i].x, r1);
         chk("row error", {31'h0, rows[i].e}, {31'h0, e1});
      end
      // Break: valid at the compare value, then overflow after 4096 ticks.
      wr(`LHSS_ADDR_BREAK_VAL, 32'h3);
      i_master.hold(1'b0, 2);
      tick(3);
      repeat (3) @(posedge CLOCK);
      rdc(`LHSS_ADDR_STATUS, 32'h01);
      rdc(`LHSS_ADDR_STATUS, 32'h00);
      rdc(`LHSS_ADDR_BREAK_VAL, 32'h3);
      tick(4096);
      repeat (3) @(posedge CLOCK);
      chk("irq", 32'h1, {31'h0, IRQ_REQ});
      rdc(`LHSS_ADDR_STATUS, 32'h10);
      repeat (2) @(posedge CLOCK);
      chk("irq", 32'h0, {31'h0, IRQ_REQ});
      rdc(`LHSS_ADDR_BREAK_VAL, 32'hfff);
      // A break event landing in each cycle of a status read is not lost.
      wr(`LHSS_ADDR_BREAK_VAL, 32'h1);
      for (int p = 0; p < 3; p++) begin
         i_master.hold(1'b1, 3);
         i_master.hold(1'b0, 3);
         apb(1'b0, `LHSS_ADDR_STATUS, 0, p, r2, e1);
         chk("first read", {31'h0, p == 0}, r2);
         repeat (3) @(posedge CLOCK);
         rdc(`LHSS_ADDR_STATUS, {31'h0, p != 0});
      end
      i_master.hold(1'b1, 3);
      // Sync byte: start on a fall, compare at 2, stop on the next fall.
      wr(`LHSS_ADDR_EDGE, 32'h10);
      wr(`LHSS_ADDR_SYNC_CMP, 32'h2);
      wr(`LHSS_ADDR_CTRL0, 32'h1);
      repeat (3) @(posedge CLOCK);
      i_master.hold(1'b0, 120);
      i_master.hold(1'b1, 40);
      i_master.hold(1'b0, 40);
      i_master.hold(1'b1, 5);
      rdc(`LHSS_ADDR_STATUS, 32'h0e);
      // Software reset of the timing hardware reports completion.
      wr(`LHSS_ADDR_CTRL0, 32'h2);
      repeat (3) @(posedge CLOCK);
      rdc(`LHSS_ADDR_STATUS, 32'h20);
      rdc(`LHSS_ADDR_CTRL0, 32'h0);
      // Rising edges: bit-serial unmasked, masked, masked then switched to
      // LIN mode with bit 12 set (which enables), then LIN mode alone.
      for (int m = 0; m < 4; m++) begin
         wr(`LHSS_ADDR_CTRL0,
            m == 0 ? 32'h4 : m == 3 ? 32'h1000 : 32'h1004);
         i_master.hold(1'b0, 4);
         i_master.hold(1'b1, 4);
         if (m == 2) begin
            wr(`LHSS_ADDR_CTRL0, 32'h1000);
            repeat (2) @(posedge CLOCK);
         end
         chk("irq", m == 0 || m == 2, {31'h0, IRQ_REQ});
         rdc(`LHSS_ADDR_STATUS, m < 3 ? 32'h40 : 32'h0);
      end
      // Reset in mid-run wipes flags and registers.
      wr(`LHSS_ADDR_SYNC_CMP, 32'h0abc);
      wr(`LHSS_ADDR_CTRL0, 32'h4);
      i_master.hold(1'b0, 4);
      i_master.hold(1'b1, 4);
      RESET <= 1'b1;
      repeat (2) @(posedge CLOCK);
      RESET <= 1'b0;
      @(posedge CLOCK);
      chk("irq", 32'h0, {31'h0, IRQ_REQ});
      rdc(`LHSS_ADDR_STATUS, 32'h0);
      rdc(`LHSS_ADDR_SYNC_CMP, 32'hffff);
      rdc(`LHSS_ADDR_CTRL0, 32'h0);
      test_done();
   end
endmodule
